// [core/fpm_mac.sv]
// Fixed-point multiply-accumulate unit with 48-bit accumulator
`timescale 1ns/100ps
`include "fpm_defs.svh"
module fpm_mac import fpm_pkg::*; (
	// Clock, reset and freeze
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	// Operation issue from decode
	input wire logic op_valid,
	input wire fpm_op_t op_code,
	input wire logic [31:0] src_a,
	input wire logic [31:0] src_b,
	input wire logic [1:0] round_imm,
	// Results to the register file
	output logic rd_valid,
	output logic [31:0] rd_data,
	output logic [47:0] acc_value
);

	// ********************************
	// Declarations
	// ********************************
	fpm_mul_if mul_bus ();
	logic [`FPM_ACC_W-1:0] acc;
	logic [`FPM_ACC_W-1:0] next_acc;
	logic [`FPM_WORD_W-1:0] next_rd_data;
	logic next_rd_valid;
	logic take;
	logic hi_sel;
	logic [`FPM_ACC_W-1:0] prod_ext;
	logic [`FPM_ACC_W+1:0] acc_wide;
	logic [`FPM_ACC_W+1:0] shifted;
	logic [`FPM_ACC_W+1:0] rounded;
	logic [`FPM_ACC_W-1:0] round_result;
	logic sat_pos;
	logic sat_neg;

	// Helper views for the checks below
	logic signed [15:0] a_lo;
	logic signed [15:0] a_hi;
	logic signed [15:0] b_lo;
	logic signed [15:0] b_hi;
	logic [31:0] acc_hi;
	logic [31:0] acc_mid;

	assign take = clk_en & op_valid;
	assign a_lo = src_a[15:0];
	assign a_hi = src_a[31:16];
	assign b_lo = src_b[15:0];
	assign b_hi = src_b[31:16];
	assign acc_hi = acc[47:16];
	assign acc_mid = acc[39:8];
	assign acc_value = acc;

	// ********************************
	// Operand selection and multiplier
	// ********************************
	assign hi_sel = (op_code == FPM_PRODUCT_HIGH_HALF) ||
		(op_code == FPM_SUM_IN_HIGH_HALF);

	// Matching halves of both sources feed the 16x16 multiplier
	assign mul_bus.mac_a = hi_sel ? src_a[31:16] : src_a[15:0]; // [RULE_10]
	assign mul_bus.mac_b = hi_sel ? src_b[31:16] : src_b[15:0]; // [RULE_10]
	assign mul_bus.int_a = src_a;
	assign mul_bus.int_b = src_b;

	fpm_mult u_mult (
		.m(mul_bus.unit)
	);

	// Full precision kept by sign extension to the accumulator width
	assign prod_ext = {{16{mul_bus.mac_prod[31]}}, mul_bus.mac_prod}; // [RULE_06]

	// ********************************
	// Rounding path
	// ********************************
	// Two guard bits keep the sign through a shift by two
	assign acc_wide = {{2{acc[47]}}, acc};

	always_comb begin
		if (round_imm == `FPM_ROUND_TWO) begin
			shifted = {acc_wide[47:0], 2'b00}; // [RULE_08] [RULE_12]
		end else begin
			// Any other immediate is taken as one
			shifted = {acc_wide[48:0], 1'b0}; // [RULE_08] [RULE_12]
		end
	end

	// Half unit sits just below the 16-bit result field
	assign rounded = shifted + `FPM_ROUND_HALF; // [RULE_12]

	// Result fits only if bits 49..31 all carry the sign
	assign sat_pos = !rounded[49] && (rounded[48:31] != 18'h0_0000);
	assign sat_neg = rounded[49] && (rounded[48:31] != 18'h3_FFFF);

	always_comb begin
		if (sat_pos) begin
			round_result = `FPM_SAT_POS; // [RULE_12]
		end else if (sat_neg) begin
			round_result = `FPM_SAT_NEG; // [RULE_12]
		end else begin
			// Low bits cleared so the move reads a clean short
			round_result = {{16{rounded[31]}}, rounded[31:16], 16'h0000};
		end
	end

	// ********************************
	// Accumulator next value
	// ********************************
	always_comb begin
		next_acc = acc;
		case (op_code)
			FPM_PRODUCT_LOW_HALF,
			FPM_PRODUCT_HIGH_HALF: begin
				next_acc = prod_ext; // [RULE_03] [RULE_11]
			end
			FPM_SUM_IN_LOW_HALF,
			FPM_SUM_IN_HIGH_HALF: begin
				// Wraps at 48 bits; there is no accumulator saturation
				next_acc = acc + prod_ext; // [RULE_03] [RULE_11]
			end
			FPM_ROUND_SUM_WORD: begin
				next_acc = round_result; // [RULE_04]
			end
			FPM_LOAD_SUM_HIGH: begin
				next_acc = {src_a, acc[15:0]}; // [RULE_05]
			end
			FPM_LOAD_SUM_LOW: begin
				next_acc = {acc[47:32], src_a}; // [RULE_05]
			end
			FPM_SUM_CLEAR: begin
				next_acc = `FPM_ACC_RESET; // [RULE_07]
			end
			default: begin
				next_acc = acc;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			acc <= `FPM_ACC_RESET;
		end else if (take) begin
			acc <= next_acc; // [RULE_03]
		end
	end

	// ********************************
	// Register file results
	// ********************************
	always_comb begin
		next_rd_valid = 1'b1;
		next_rd_data = rd_data;
		case (op_code)
			FPM_INTEGER_PRODUCT_OP: begin
				next_rd_data = mul_bus.int_prod[31:0]; // [RULE_02]
			end
			FPM_MOVE_SUM_HIGH: begin
				next_rd_data = acc[47:16]; // [RULE_09] [RULE_05]
			end
			FPM_MOVE_SUM_MID: begin
				next_rd_data = acc[39:8]; // [RULE_05]
			end
			default: begin
				next_rd_valid = 1'b0;
				next_rd_data = rd_data;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rd_valid <= 1'b0;
		end else if (clk_en) begin
			rd_valid <= op_valid && next_rd_valid;
		end
	end

	// Data holds between results so a late read still sees it
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rd_data <= `FPM_WORD_RESET;
		end else if (take) begin
			rd_data <= next_rd_data;
		end
	end

	// ********************************
	// Checks
	// ********************************
	int_low_word_a: assert property ( // [RULE_02]
		@(posedge core_clk) disable iff (reset)
		(take && op_code == FPM_INTEGER_PRODUCT_OP) |=>
		(rd_valid && rd_data == 32'($past(src_a) * $past(src_b))))
		else $error("integer product low word wrong");

	// All operands signed, so the product is formed at the full 48 bits
	prod_low_load_a: assert property ( // [RULE_10]
		@(posedge core_clk) disable iff (reset)
		(take && op_code == FPM_PRODUCT_LOW_HALF) |=>
		($signed(acc) == $signed($past(a_lo)) * $signed($past(b_lo))))
		else $error("low half product not loaded");

	sum_high_add_a: assert property ( // [RULE_11]
		@(posedge core_clk) disable iff (reset)
		(take && op_code == FPM_SUM_IN_HIGH_HALF) |=>
		($signed(acc) == $signed($past(acc)) +
		$signed($past(a_hi)) * $signed($past(b_hi))))
		else $error("high half accumulate wrong");

	sum_clear_zero_a: assert property ( // [RULE_07]
		@(posedge core_clk) disable iff (reset)
		(take && op_code == FPM_SUM_CLEAR) |=> (acc == 48'h0000_0000_0000))
		else $error("accumulator not cleared");

	round_form_a: assert property ( // [RULE_12]
		@(posedge core_clk) disable iff (reset)
		(take && op_code == FPM_ROUND_SUM_WORD) |=>
		(acc[15:0] == 16'h0000 &&
		(acc[47:31] == 17'h0_0000 || acc[47:31] == 17'h1_FFFF)))
		else $error("rounded value not a clean 16-bit result");

	round_zero_a: assert property ( // [RULE_08]
		@(posedge core_clk) disable iff (reset)
		// Shift by two halves the range that rounds away to zero
		(take && op_code == FPM_ROUND_SUM_WORD && !acc[47] &&
		(acc < ((round_imm == `FPM_ROUND_TWO) ? 48'h0000_0000_2000 :
		48'h0000_0000_4000))) |=>
		(acc == 48'h0000_0000_0000))
		else $error("small positive value did not round to zero");

	move_high_a: assert property ( // [RULE_09]
		@(posedge core_clk) disable iff (reset)
		(take && op_code == FPM_MOVE_SUM_HIGH) |=>
		(rd_valid && rd_data == $past(acc_hi)))
		else $error("move high returned wrong bits");

	move_mid_a: assert property ( // [RULE_05]
		@(posedge core_clk) disable iff (reset)
		(take && op_code == FPM_MOVE_SUM_MID) |=>
		(rd_valid && rd_data == $past(acc_mid) && $stable(acc)))
		else $error("move mid wrong or disturbed accumulator");

	freeze_hold_a: assert property ( // [RULE_03]
		@(posedge core_clk) disable iff (reset)
		(!clk_en) |=> ($stable(acc) && $stable(rd_data) && $stable(rd_valid)))
		else $error("state changed while frozen");

	idle_hold_a: assert property ( // [RULE_11]
		@(posedge core_clk) disable iff (reset)
		(clk_en && !op_valid) |=> ($stable(acc) && !rd_valid))
		else $error("accumulator changed without an operation");

	valid_pulse_a: assert property ( // [RULE_05]
		@(posedge core_clk) disable iff (reset)
		(take && (op_code == FPM_SUM_IN_LOW_HALF ||
		op_code == FPM_ROUND_SUM_WORD)) |=> !rd_valid)
		else $error("result strobe on accumulator-only operation");

	prod_high_load_a: assert property ( // [RULE_10]
		@(posedge core_clk) disable iff (reset)
		(take && op_code == FPM_PRODUCT_HIGH_HALF) |=>
		($signed(acc) == $signed($past(a_hi)) * $signed($past(b_hi))))
		else $error("high half product not loaded");

	sum_low_add_a: assert property ( // [RULE_06]
		@(posedge core_clk) disable iff (reset)
		(take && op_code == FPM_SUM_IN_LOW_HALF) |=>
		($signed(acc) == $signed($past(acc)) +
		$signed($past(a_lo)) * $signed($past(b_lo))))
		else $error("low half accumulate wrong");

	load_high_keep_a: assert property ( // [RULE_05]
		@(posedge core_clk) disable iff (reset)
		(take && op_code == FPM_LOAD_SUM_HIGH) |=>
		(acc[47:16] == $past(src_a) && acc[15:0] == $past(acc[15:0])))
		else $error("high load wrong or low bits disturbed");

	// Any positive value of 2**30 or more overflows the short
	round_sat_a: assert property ( // [RULE_12]
		@(posedge core_clk) disable iff (reset)
		(take && op_code == FPM_ROUND_SUM_WORD && !acc[47] &&
		acc[46:30] != 17'h0_0000) |=> (acc == `FPM_SAT_POS))
		else $error("large positive value did not saturate");

endmodule

// [core/fpm_defs.svh]
// Constants of the fixed-point multiply-accumulate unit
// Contract
// [RULE_01] The multiplier of the unit takes two 16-bit operands per operation.
// [RULE_02] The integer multiply forms a 64-bit product and returns its low 32 bits.
// [RULE_03] A 48-bit accumulator is the destination of multiply and multiply-accumulate.
// [RULE_04] A round operation rounds the accumulator and writes it back to itself.
// [RULE_05] Transfer operations move data between accumulator and general registers.
// [RULE_06] Multiply-accumulate treats operands as signed and keeps full precision.
// [RULE_07] The accumulator clears to zero by operation, as a sequence must begin.
// [RULE_08] Rounding takes an immediate of 1 or 2, giving a 16-bit signed result.
// [RULE_09] Move-sum-high copies the top 32 bits of the accumulator to a register.
// [RULE_10] Multiply and accumulate each have low-half and high-half forms.
// [RULE_11] Multiply forms overwrite the accumulator; accumulate forms add to it.
// [RULE_12] Rounding shifts left by the immediate, adds a half unit, saturates.
`ifndef FPM_DEFS_SVH
`define FPM_DEFS_SVH

// ********************************
// Widths
// ********************************
`define FPM_ACC_W 48
`define FPM_WORD_W 32
`define FPM_HALF_W 16

// ********************************
// Reset values and rounding figures
// ********************************
`define FPM_ACC_RESET 48'h0000_0000_0000
`define FPM_WORD_RESET 32'h0000_0000
`define FPM_ROUND_HALF 50'h0_0000_0000_8000
`define FPM_SAT_POS 48'h0000_7FFF_0000
`define FPM_SAT_NEG 48'hFFFF_8000_0000
`define FPM_ROUND_TWO 2'h2

`endif

// [core/fpm_pkg.sv]
// Operation codes of the multiply-accumulate unit
package fpm_pkg;
	typedef enum logic [3:0] {
		FPM_IDLE,
		FPM_INTEGER_PRODUCT_OP,
		FPM_PRODUCT_LOW_HALF,
		FPM_PRODUCT_HIGH_HALF,
		FPM_SUM_IN_LOW_HALF,
		FPM_SUM_IN_HIGH_HALF,
		FPM_ROUND_SUM_WORD,
		FPM_MOVE_SUM_HIGH,
		FPM_MOVE_SUM_MID,
		FPM_LOAD_SUM_HIGH,
		FPM_LOAD_SUM_LOW,
		FPM_SUM_CLEAR
	} fpm_op_t;
endpackage

// [core/fpm_mul_if.sv]
// Operand and product bundle between the unit and its multiplier
`timescale 1ns/100ps
interface fpm_mul_if;
	logic [15:0] mac_a;
	logic [15:0] mac_b;
	logic [31:0] mac_prod;
	logic [31:0] int_a;
	logic [31:0] int_b;
	logic [63:0] int_prod;
	modport unit (
		input mac_a,
		input mac_b,
		input int_a,
		input int_b,
		output mac_prod,
		output int_prod
	);
	modport user (
		output mac_a,
		output mac_b,
		output int_a,
		output int_b,
		input mac_prod,
		input int_prod
	);
endinterface

// [core/fpm_mult.sv]
// Signed 16x16 and full 32x32 multipliers
`timescale 1ns/100ps
module fpm_mult (
	// Operands and products
	fpm_mul_if.unit m
);
	// Both operands signed, so the product is sign-extended in width
	assign m.mac_prod = $signed(m.mac_a) * $signed(m.mac_b); // [RULE_01] [RULE_06]
	// Low word is identical for signed and unsigned operands
	assign m.int_prod = m.int_a * m.int_b; // [RULE_02]
endmodule

// [tb/fpm_rf_model.sv]
// Register file side that takes the unit's write-backs
`timescale 1ns/100ps
module fpm_rf_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	// Write-back from the unit
	input wire logic rd_valid,
	input wire logic [31:0] rd_data,
	// Captured state
	output logic [31:0] wb_data,
	output logic [15:0] wb_count
);
	// Frozen edges must not count a held pulse twice
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			wb_data <= 32'h0000_0000;
			wb_count <= 16'h0000;
		end else if (rd_valid && clk_en) begin
			wb_data <= rd_data;
			wb_count <= wb_count + 16'h0001;
		end
	end
endmodule

// [tb/tb.sv]
// Self-checking bench of the multiply-accumulate unit
`timescale 1ns/100ps
module tb;
	import fpm_pkg::*;
	logic core_clk, reset, clk_en, op_valid, rd_valid, rv_exp;
	fpm_op_t op_code;
	logic [31:0] src_a, src_b, rd_data, wb_data, rd_exp;
	logic [1:0] round_imm;
	logic [47:0] acc_value, acc_exp;
	logic [15:0] wb_count, wb_exp;
	int errors, comparisons, cycles;
	logic [31:0] vals [4] = '{32'h0000_3fff, 32'h0000_4000,
		32'hffff_c000, 32'h7fff_ffff};

	fpm_mac dut (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
		.op_valid(op_valid), .op_code(op_code), .src_a(src_a),
		.src_b(src_b), .round_imm(round_imm), .rd_valid(rd_valid),
		.rd_data(rd_data), .acc_value(acc_value));
	fpm_rf_model rf (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
		.rd_valid(rd_valid), .rd_data(rd_data), .wb_data(wb_data),
		.wb_count(wb_count));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cycles++;
		if (cycles > 5000) begin
			errors++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		if (errors == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(string n, logic [47:0] e, logic [47:0] s);
		comparisons++;
		if (s !== e) begin
			errors++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask

	// Shift, add half unit, saturate to a signed halfword
	function automatic logic [47:0] rnd(logic [47:0] a, logic [1:0] i);
		logic [49:0] w;
		w = {{2{a[47]}}, a} << ((i == 2'h2) ? 2 : 1);
		w = w + 50'h0_0000_0000_8000;
		if (w[49:31] != {19{w[49]}})
			return w[49] ? 48'hffff_8000_0000 : 48'h0000_7fff_0000;
		return {{16{w[31]}}, w[31:16], 16'h0000};
	endfunction

	task automatic predict(fpm_op_t o, logic [31:0] a, logic [31:0] b,
		logic [1:0] i);
		logic signed [31:0] pl, ph, p;
		logic [63:0] q;
		pl = $signed(a[15:0]) * $signed(b[15:0]);
		ph = $signed(a[31:16]) * $signed(b[31:16]);
		q = {32'h0000_0000, a} * {32'h0000_0000, b};
		p = (o == FPM_PRODUCT_HIGH_HALF || o == FPM_SUM_IN_HIGH_HALF) ? ph : pl;
		rv_exp = 1'b0;
		case (o)
			FPM_INTEGER_PRODUCT_OP: rd_exp = q[31:0];
			FPM_PRODUCT_LOW_HALF, FPM_PRODUCT_HIGH_HALF:
				acc_exp = {{16{p[31]}}, p};
			FPM_SUM_IN_LOW_HALF, FPM_SUM_IN_HIGH_HALF:
				acc_exp = acc_exp + {{16{p[31]}}, p};
			FPM_ROUND_SUM_WORD: acc_exp = rnd(acc_exp, i);
			FPM_MOVE_SUM_HIGH: rd_exp = acc_exp[47:16];
			FPM_MOVE_SUM_MID: rd_exp = acc_exp[39:8];
			FPM_LOAD_SUM_HIGH: acc_exp[47:16] = a;
			FPM_LOAD_SUM_LOW: acc_exp[31:0] = a;
			FPM_SUM_CLEAR: acc_exp = 48'h0000_0000_0000;
			default: ;
		endcase
		if (o inside {FPM_INTEGER_PRODUCT_OP, FPM_MOVE_SUM_HIGH,
			FPM_MOVE_SUM_MID}) begin
			rv_exp = 1'b1;
			wb_exp++;
		end
	endtask

	// Inputs change 1 ns after the edge; results checked after the next
	task automatic op(fpm_op_t o, logic [31:0] a, logic [31:0] b,
		logic [1:0] i, logic v, logic e);
		op_valid = v;
		clk_en = e;
		op_code = o;
		src_a = a;
		src_b = b;
		round_imm = i;
		@(posedge core_clk);
		#1;
		if (v && e)
			predict(o, a, b, i);
		else if (e)
			rv_exp = 1'b0;
		chk("acc_value", acc_exp, acc_value);
		chk("rd_data", 48'(rd_exp), 48'(rd_data));
		chk("rd_valid", 48'(rv_exp), 48'(rd_valid));
	endtask

	initial begin
		errors = 0;
		comparisons = 0;
		cycles = 0;
		reset = 1'b1;
		clk_en = 1'b1;
		op_valid = 1'b0;
		op_code = FPM_IDLE;
		src_a = 32'h0000_0000;
		src_b = 32'h0000_0000;
		round_imm = 2'h0;
		acc_exp = 48'h0000_0000_0000;
		rd_exp = 32'h0000_0000;
		rv_exp = 1'b0;
		wb_exp = 16'h0000;
		void'($urandom(32'h14066bbe));
		repeat (20) @(posedge core_clk);
		#1;
		reset = 1'b0;
		op(FPM_SUM_CLEAR, 0, 0, 0, 1, 1);
		// Largest products overflow 32 bits only in the wide sum
		for (int k = 0; k < 8; k++)
			op(k[0] ? FPM_SUM_IN_HIGH_HALF : FPM_SUM_IN_LOW_HALF,
				32'h8000_8000, 32'h8000_8000, 0, 1, 1);
		op(FPM_MOVE_SUM_HIGH, 0, 0, 0, 1, 1);
		op(FPM_MOVE_SUM_MID, 0, 0, 0, 1, 1);
		op(FPM_PRODUCT_HIGH_HALF, 32'h8000_0001, 32'h7fff_ffff, 0, 1, 1);
		op(FPM_SUM_IN_LOW_HALF, 5, 5, 0, 1, 0);
		op(FPM_SUM_IN_LOW_HALF, 5, 5, 0, 0, 1);
		op(FPM_INTEGER_PRODUCT_OP, 32'hffff_ffff, 32'hffff_ffff, 0, 1, 1);
		op(FPM_INTEGER_PRODUCT_OP, 32'h8000_0001, 3, 0, 1, 1);
		foreach (vals[n])
			for (int i = 1; i < 3; i++) begin
				op(FPM_LOAD_SUM_HIGH, vals[n], 0, 0, 1, 1);
				op(FPM_LOAD_SUM_LOW, ~vals[n], 0, 0, 1, 1);
				op(FPM_ROUND_SUM_WORD, 0, 0, 2'(i), 1, 1);
				op(FPM_MOVE_SUM_HIGH, 0, 0, 0, 1, 1);
			end
		// Small positive sums round to zero in both forms
		for (int i = 1; i < 3; i++) begin
			op(FPM_SUM_CLEAR, 0, 0, 0, 1, 1);
			op(FPM_LOAD_SUM_LOW, 32'h0000_1fff, 0, 0, 1, 1);
			op(FPM_ROUND_SUM_WORD, 0, 0, 2'(i), 1, 1);
			op(FPM_MOVE_SUM_HIGH, 0, 0, 0, 1, 1);
		end
		for (int k = 0; k < 600; k++) begin
			if (k == 300) begin
				reset = 1'b1;
				@(posedge core_clk);
				#1;
				reset = 1'b0;
				acc_exp = 48'h0000_0000_0000;
				rd_exp = 32'h0000_0000;
				rv_exp = 1'b0;
				wb_exp = 16'h0000;
			end
			op(fpm_op_t'($urandom_range(11)), $urandom, $urandom,
				2'($urandom_range(3)), $urandom_range(7) != 0,
				$urandom_range(7) != 0);
		end
		op(FPM_IDLE, 0, 0, 0, 1, 1);
		chk("wb_data", 48'(rd_exp), 48'(wb_data));
		chk("wb_count", 48'(wb_exp), 48'(wb_count));
		wrap_up();
	end
endmodule
